// File: common/rst_seq_regs.svh
`ifndef RST_SEQ_REGS_SVH
`define RST_SEQ_REGS_SVH

// ==================================================================
// Register map
`define RSQ_ADDR_STATUS 4'h0
`define RSQ_ADDR_CTRL 4'h1

// STATUS fields
`define RSQ_ST_BOR_N 0
`define RSQ_ST_POR_N 1
`define RSQ_ST_PD 2
`define RSQ_ST_TO 3
`define RSQ_ST_CAUSE_LSB 4
`define RSQ_ST_CAUSE_MSB 6

// CTRL fields (write: sleep, wdt_clr; read: sleeping, waking, state)
`define RSQ_CT_SLEEP 0
`define RSQ_CT_WDT_CLR 1
`define RSQ_CT_WAKING 1
`define RSQ_CT_STATE_LSB 2
`define RSQ_CT_STATE_MSB 6

// ==================================================================
// Oscillator select codes
`define RSQ_OSC_RC 2'b11
`define RSQ_OSC_HS 2'b10
`define RSQ_OSC_XT 2'b01
`define RSQ_OSC_LP 2'b00

// ==================================================================
// Timing
`define RSQ_CLK_PERIOD_NS 40
`define RSQ_POWERUP_DELAY_TIMER_TIME_US 72000
`define RSQ_RC_OSC_KHZ 32
`define RSQ_OST_CYCLES 1024
`define RSQ_BOR_MIN_NS 100000
`define RSQ_PIN_FILTER_NS 320

// ==================================================================
// Input pin slots and their idle levels
`define RSQ_IN_SUPPLY 0
`define RSQ_IN_BROWN 1
`define RSQ_IN_PIN 2
`define RSQ_IN_WDT 3
`define RSQ_IN_RC 4
`define RSQ_IN_OSC 5
`define RSQ_PIN_IDLE 6'h04

`endif

// File: common/rst_seq_pkg.sv
package rst_seq_pkg;

   typedef struct packed {
      logic [1:0] osc_select_field;
      logic powerup_delay_enable_cfg;
      logic brownout_enable_cfg;
   } cfg_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   typedef enum logic [2:0] {
      CAUSE_POR = 3'h0,
      CAUSE_BOR = 3'h1,
      CAUSE_PIN_RUN = 3'h2,
      CAUSE_PIN_SLEEP = 3'h3,
      CAUSE_WDT_RUN = 3'h4,
      CAUSE_WDT_WAKE = 3'h5,
      CAUSE_IRQ_WAKE = 3'h6
   } cause_e;

   typedef enum logic [4:0] {
      ST_RUN = 5'b00001,
      ST_BOR_WAIT = 5'b00010,
      ST_POWERUP_DELAY_TIMER = 5'b00100,
      ST_OST = 5'b01000,
      ST_WDT_RST = 5'b10000
   } seq_state_e;

endpackage

// File: core/pin_conditioner.sv
`timescale 1ns/1ps
module pin_conditioner
#(
   parameter int FILT_CYC = 1,
   parameter bit IDLE = 1'b0
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Asynchronous pin in, filtered level out
   input wire logic pin,
   output logic q
);
   localparam int CW = $clog2(FILT_CYC + 1);
   logic meta;
   logic sync;
   logic [CW-1:0] cnt;

   // ===============================================================
   // Two-stage synchroniser; only sync reads meta
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta <= IDLE;
         sync <= IDLE;
      end
      else
      begin
         meta <= pin;
         sync <= meta;
      end
   end

   // ===============================================================
   // Level must differ for FILT_CYC cycles before it is accepted
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q <= IDLE;
         cnt <= '0;
      end
      else if (sync == q)
         cnt <= '0;
      else if (cnt == CW'(FILT_CYC - 1))
      begin
         q <= sync;
         cnt <= '0;
      end
      else
         cnt <= cnt + 1'b1;
   end
endmodule

// File: core/down_counter.sv
`timescale 1ns/1ps
module down_counter
#(
   parameter int W = 12
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic tick,
   // Status
   output logic done
);
   logic [W-1:0] cnt;

   assign done = (cnt == '0);

   // ===============================================================
   // Reload wins over counting; stops at zero
   always_ff @(posedge clk)
   begin
      if (srst)
         cnt <= '0;
      else if (load)
         cnt <= load_val;
      else if (tick && !done)
         cnt <= cnt - 1'b1;
   end
endmodule

// File: core/reset_and_startup_sequencer.sv
`timescale 1ns/1ps
`include "rst_seq_regs.svh"
// Operation
// - Distinguish seven reset causes
// - Some registers keep contents except power-on
// - Watchdog wake-up leaves registers untouched
// - Timeout and sleep flags encode the cause
// - Filter short pulses on reset pin
// - Watchdog reset never drives reset pin
// - Supply rise makes power-on reset
// - Power-up delay holds reset after power-on
// - Power-up delay clocked by internal RC
// - Config bit enables power-up delay
// - Start-up count follows power-up delay
// - Start-up count only crystal modes
// - Brown-out enable gates brown-out reset
// - Brown-out needs minimum low duration
// - Hold until supply recovers, then delay
// - New dip restarts brown-out sequence
// - Brown-out enable forces power-up delay
// - Release after last applicable stage
// - Pin release starts run at once
// - Oscillator select field encoding
// - Power-up delay enable is active low
module reset_and_startup_sequencer
#(
   parameter int POWERUP_DELAY_TIMER_TICKS = `RSQ_POWERUP_DELAY_TIMER_TIME_US * `RSQ_RC_OSC_KHZ / 1000,
   parameter int OST_CYCLES = `RSQ_OST_CYCLES,
   parameter int BOR_CYCLES =
      (`RSQ_BOR_MIN_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS,
   parameter int PIN_FILT_CYCLES =
      (`RSQ_PIN_FILTER_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SRST,
   // Configuration word
   input wire rst_seq_pkg::cfg_s CFG,
   // Asynchronous reset sources and clocks
   input wire logic SUPPLY_RISE,
   input wire logic BROWNOUT_LOW,
   input wire logic EXT_RST_N,
   input wire logic WDT_TIMEOUT,
   input wire logic RC_OSC,
   input wire logic OSC_IN,
   // Core events
   input wire logic WAKE_IRQ,
   // Register port
   input wire rst_seq_pkg::bus_req_s REQ,
   output logic [7:0] RDATA,
   // Reset outputs
   output logic CORE_RST,
   output logic COLD_RST,
   output logic CORE_STALL,
   output rst_seq_pkg::cause_e RST_CAUSE
);
   import rst_seq_pkg::*;

   localparam int NPIN = 6;
   localparam int PW = $clog2(POWERUP_DELAY_TIMER_TICKS + 1);
   localparam int OW = $clog2(OST_CYCLES + 1);
   localparam int BW = $clog2(BOR_CYCLES + 1);

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_q;
   logic [NPIN-1:0] pin_d;
   logic [NPIN-1:0] rise;
   seq_state_e state;
   seq_state_e next_state;
   logic waking;
   logic next_waking;
   logic sleeping;
   logic next_sleeping;
   logic por_pend;
   logic por_seq;
   logic next_por_seq;
   logic to_flag;
   logic pd_flag;
   logic por_n;
   logic bor_n;
   logic next_to;
   logic next_pd;
   logic next_por_n;
   logic next_bor_n;
   cause_e next_cause;
   logic next_core_rst;
   logic powerup_delay_timer_done;
   logic ost_done;
   logic bor_done;

   // ===============================================================
   // Decoding helpers
   function automatic logic is_crystal(input cfg_s c);
      is_crystal = (c.osc_select_field != `RSQ_OSC_RC);
   endfunction

   function automatic seq_state_e first_stage(input cfg_s c,
                                             input logic powerup_delay_timer);
      if (powerup_delay_timer)
         first_stage = ST_POWERUP_DELAY_TIMER;
      else if (is_crystal(c))
         first_stage = ST_OST;
      else
         first_stage = ST_RUN;
   endfunction

   // ===============================================================
   // Input conditioning
   assign pin_raw = {OSC_IN, RC_OSC, WDT_TIMEOUT, EXT_RST_N,
                     BROWNOUT_LOW, SUPPLY_RISE};

   generate
      for (genvar i = 0; i < NPIN; i++)
      begin : g_in
         pin_conditioner #(
            .FILT_CYC(i == `RSQ_IN_PIN ? PIN_FILT_CYCLES : 1),
            .IDLE(i == `RSQ_IN_PIN)
         ) u_cond (
            .clk(CORE_CLK),
            .srst(SRST),
            .pin(pin_raw[i]),
            .q(pin_q[i])
         );
      end
   endgenerate

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         pin_d <= `RSQ_PIN_IDLE;
      else
         pin_d <= pin_q;
   end

   assign rise = pin_q & ~pin_d;

   wire supply_evt = rise[`RSQ_IN_SUPPLY];
   wire por_evt = supply_evt | por_pend;
   wire bo_low = pin_q[`RSQ_IN_BROWN] & CFG.brownout_enable_cfg;
   wire pin_low = ~pin_q[`RSQ_IN_PIN];
   wire pin_evt = pin_low & pin_d[`RSQ_IN_PIN];
   wire wdt_evt = rise[`RSQ_IN_WDT];
   wire rc_tick = rise[`RSQ_IN_RC];
   wire osc_tick = rise[`RSQ_IN_OSC];

   // Delay in use when enabled low, or forced by brown-out enable
   wire use_powerup_delay_timer = !CFG.powerup_delay_enable_cfg
                   || CFG.brownout_enable_cfg;
   wire bor_evt = bo_low && bor_done && state != ST_BOR_WAIT;
   wire in_run = (state == ST_RUN);
   wire wdt_run = wdt_evt && in_run && !sleeping;
   wire wake_evt = sleeping && in_run && (wdt_evt || WAKE_IRQ);

   // ===============================================================
   // Register port decode
   wire wr_status = REQ.wr && REQ.addr == `RSQ_ADDR_STATUS;
   wire wr_ctrl = REQ.wr && REQ.addr == `RSQ_ADDR_CTRL;
   wire sleep_req = wr_ctrl && REQ.wdata[`RSQ_CT_SLEEP] && in_run
                    && !CORE_RST && !sleeping;
   wire wdt_clr = wr_ctrl && REQ.wdata[`RSQ_CT_WDT_CLR];
   wire [7:0] status_rd = {1'b0, RST_CAUSE, to_flag, pd_flag, por_n, bor_n};
   wire [7:0] ctrl_rd = {1'b0, state, waking, sleeping};
   wire [7:0] rd_mux = (REQ.addr == `RSQ_ADDR_STATUS) ? status_rd :
                       (REQ.addr == `RSQ_ADDR_CTRL) ? ctrl_rd : 8'h00;

   // ===============================================================
   // Delay timers
   down_counter #(.W(PW)) u_powerup_delay_timer (
      .clk(CORE_CLK),
      .srst(SRST),
      .load(next_state == ST_POWERUP_DELAY_TIMER && (state != ST_POWERUP_DELAY_TIMER || por_evt)),
      .load_val(PW'(POWERUP_DELAY_TIMER_TICKS)),
      .tick(rc_tick),
      .done(powerup_delay_timer_done)
   );

   down_counter #(.W(OW)) u_ost (
      .clk(CORE_CLK),
      .srst(SRST),
      .load(next_state == ST_OST && (state != ST_OST || por_evt)),
      .load_val(OW'(OST_CYCLES)),
      .tick(osc_tick),
      .done(ost_done)
   );

   // Held loaded while the supply is good, so a dip is timed afresh
   down_counter #(.W(BW)) u_bor (
      .clk(CORE_CLK),
      .srst(SRST),
      .load(!bo_low),
      .load_val(BW'(BOR_CYCLES)),
      .tick(1'b1),
      .done(bor_done)
   );

   // ===============================================================
   // Sequencer
   always_comb
   begin
      next_state = state;
      next_waking = waking;
      case (state)
         ST_RUN:
         begin
            if (wdt_run)
               next_state = ST_WDT_RST;
            else if (wake_evt && is_crystal(CFG))
            begin
               next_state = ST_OST;
               next_waking = 1'b1;
            end
         end
         ST_BOR_WAIT:
            if (!bo_low)
               next_state = ST_POWERUP_DELAY_TIMER;
         ST_POWERUP_DELAY_TIMER:
         begin
            if (bo_low)
               next_state = ST_BOR_WAIT;
            else if (powerup_delay_timer_done)
               next_state = is_crystal(CFG) ? ST_OST : ST_RUN;
         end
         ST_OST:
            if (ost_done)
            begin
               next_state = ST_RUN;
               next_waking = 1'b0;
            end
         ST_WDT_RST:
            next_state = ST_RUN;
         default:
            next_state = ST_RUN;
      endcase
      if (pin_evt)
         next_waking = 1'b0;
      if (bor_evt)
      begin
         next_state = ST_BOR_WAIT;
         next_waking = 1'b0;
      end
      if (por_evt)
      begin
         next_state = first_stage(CFG, use_powerup_delay_timer);
         next_waking = 1'b0;
      end
   end

   assign next_sleeping = (por_evt || bor_evt || pin_evt || wake_evt)
                          ? 1'b0 : (sleeping || sleep_req);
   assign next_por_seq = (por_evt || por_seq) && next_state != ST_RUN;

   // Wake-up start-up count stalls the core but keeps its state
   assign next_core_rst = pin_low
      || (next_state != ST_RUN && !next_waking);

   // ===============================================================
   // Status flags; hardware events are applied last so they win
   always_comb
   begin
      next_to = to_flag;
      next_pd = pd_flag;
      next_cause = RST_CAUSE;
      next_por_n = por_n | (wr_status & REQ.wdata[`RSQ_ST_POR_N]);
      next_bor_n = bor_n | (wr_status & REQ.wdata[`RSQ_ST_BOR_N]);
      if (sleep_req)
      begin
         next_to = 1'b1;
         next_pd = 1'b0;
      end
      if (wdt_clr)
      begin
         next_to = 1'b1;
         next_pd = 1'b1;
      end
      if (wake_evt)
      begin
         next_to = !wdt_evt;
         next_pd = 1'b0;
         next_cause = wdt_evt ? CAUSE_WDT_WAKE : CAUSE_IRQ_WAKE;
      end
      if (pin_evt)
      begin
         if (sleeping)
         begin
            next_to = 1'b1;
            next_pd = 1'b0;
         end
         next_cause = sleeping ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
      end
      if (wdt_run)
      begin
         next_to = 1'b0;
         next_pd = 1'b1;
         next_cause = CAUSE_WDT_RUN;
      end
      if (bor_evt)
      begin
         next_to = 1'b1;
         next_pd = 1'b1;
         next_bor_n = 1'b0;
         next_cause = CAUSE_BOR;
      end
      if (por_evt)
      begin
         next_to = 1'b1;
         next_pd = 1'b1;
         next_por_n = 1'b0;
         next_cause = CAUSE_POR;
      end
   end

   // ===============================================================
   // State registers
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         state <= ST_RUN;
         waking <= 1'b0;
         sleeping <= 1'b0;
         por_pend <= 1'b1;
         por_seq <= 1'b1;
      end
      else
      begin
         state <= next_state;
         waking <= next_waking;
         sleeping <= next_sleeping;
         por_pend <= 1'b0;
         por_seq <= next_por_seq;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         to_flag <= 1'b1;
         pd_flag <= 1'b1;
         por_n <= 1'b0;
         bor_n <= 1'b0;
         RST_CAUSE <= CAUSE_POR;
      end
      else
      begin
         to_flag <= next_to;
         pd_flag <= next_pd;
         por_n <= next_por_n;
         bor_n <= next_bor_n;
         RST_CAUSE <= next_cause;
      end
   end

   // ===============================================================
   // Outputs
   // Cold reset marks persistent storage as invalid; nothing else
   // clears that storage, so warm resets leave it intact
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         CORE_RST <= 1'b1;
         COLD_RST <= 1'b1;
         CORE_STALL <= 1'b0;
         RDATA <= 8'h00;
      end
      else
      begin
         CORE_RST <= next_core_rst;
         COLD_RST <= next_por_seq;
         CORE_STALL <= next_sleeping || (next_state == ST_OST && next_waking);
         RDATA <= REQ.rd ? rd_mux : 8'h00;
      end
   end

   // ===============================================================
   // Assertions
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (SRST);

   property p_por_flags;
      por_evt |=> to_flag && pd_flag && !por_n && RST_CAUSE == CAUSE_POR;
   endproperty
   a_por_flags: assert property (p_por_flags)
      else $error("flags wrong after power-on");

   property p_powerup_delay_timer_hold;
      state == ST_POWERUP_DELAY_TIMER |-> CORE_RST;
   endproperty
   a_powerup_delay_timer_hold: assert property (p_powerup_delay_timer_hold)
      else $error("reset dropped during power-up delay");

   property p_bor_gate;
      !CFG.brownout_enable_cfg && in_run && !por_evt |=>
         state != ST_BOR_WAIT;
   endproperty
   a_bor_gate: assert property (p_bor_gate)
      else $error("brown-out acted while disabled");

   property p_bor_recover;
      state == ST_BOR_WAIT && !bo_low && !por_evt |=> state == ST_POWERUP_DELAY_TIMER;
   endproperty
   a_bor_recover: assert property (p_bor_recover)
      else $error("no power-up delay after brown-out");

   property p_bor_restart;
      state == ST_POWERUP_DELAY_TIMER && bo_low && !por_evt |=> state == ST_BOR_WAIT;
   endproperty
   a_bor_restart: assert property (p_bor_restart)
      else $error("delay not abandoned on new dip");

   property p_ost_crystal;
      state == ST_OST |-> $past(CFG.osc_select_field) != `RSQ_OSC_RC;
   endproperty
   a_ost_crystal: assert property (p_ost_crystal)
      else $error("start-up count in RC mode");

   property p_release;
      state == ST_OST && ost_done && !waking && !pin_low && !por_evt
         && !bor_evt |=> state == ST_RUN && !CORE_RST;
   endproperty
   a_release: assert property (p_release)
      else $error("reset not released after start-up count");

   property p_pin_release;
      pin_low ##1 (!pin_low && in_run && !por_evt && !bor_evt && !wdt_run)
         |=> !CORE_RST;
   endproperty
   a_pin_release: assert property (p_pin_release)
      else $error("run not resumed on pin release");

   property p_wake_keep;
      state == ST_OST && waking && !pin_low && !por_evt && !bor_evt
         |=> !CORE_RST;
   endproperty
   a_wake_keep: assert property (p_wake_keep)
      else $error("core reset during wake-up");

   property p_wdt_flags;
      wdt_run && !por_evt && !bor_evt |=> !to_flag && pd_flag && CORE_RST
         ##1 !CORE_RST || pin_low;
   endproperty
   a_wdt_flags: assert property (p_wdt_flags)
      else $error("watchdog reset flags or pulse wrong");

   property p_rdata_idle;
      !$past(REQ.rd) |-> RDATA == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read slot");

   c_por_run: cover property (por_seq ##1 !por_seq && !CORE_RST);
   c_bor_restart: cover property (state == ST_POWERUP_DELAY_TIMER ##1 state == ST_BOR_WAIT);
   c_wake_ost: cover property (state == ST_OST && waking ##1 state == ST_RUN);
   c_pin_reset: cover property (pin_evt && sleeping);
endmodule

// File: sim/osc_model.sv
`timescale 1ns/1ps
module osc_model
#(
   parameter int RC_HALF_NS = 97,
   parameter int OSC_HALF_NS = 83
)
(
   // Oscillator outputs
   output logic rc_clk,
   output logic osc_clk
);
   // ==========
   // Free-running clocks
   // Odd half periods put only every 20th edge of each clock on a core clock edge
   initial
   begin
      rc_clk = 1'b0;
      osc_clk = 1'b0;
   end
   always #(RC_HALF_NS) rc_clk = ~rc_clk;
   // External drive in place of a crystal
   always #(OSC_HALF_NS) osc_clk = ~osc_clk;
endmodule

// File: sim/reset_and_startup_sequencer_tb.sv
`timescale 1ns/1ps
module reset_and_startup_sequencer_tb;
   import rst_seq_pkg::*;
   // ==========
   // Signals
   logic clk = 1'b0;
   logic srst = 1'b1;
   cfg_s cfg = 4'h4;
   logic supply = 1'b0;
   logic brown = 1'b0;
   logic pin_n = 1'b1;
   logic wdt = 1'b0;
   logic wake = 1'b0;
   bus_req_s req = '0;
   logic [7:0] rdata;
   logic core_rst;
   logic cold_rst;
   logic stall;
   cause_e cause;
   logic rc_clk;
   logic osc_clk;
   logic [7:0] exp_wake [3] = '{8'h53, 8'h3B, 8'h6B};
   int err_total = 0;
   int checked = 0;
   int n;

   always #20 clk = ~clk;

   osc_model i_osc
   (
      .rc_clk(rc_clk),
      .osc_clk(osc_clk)
   );

   reset_and_startup_sequencer
   #(
      .POWERUP_DELAY_TIMER_TICKS(8),
      .OST_CYCLES(8),
      .BOR_CYCLES(4),
      .PIN_FILT_CYCLES(2)
   )
   i_dut
   (
      .CORE_CLK(clk),
      .SRST(srst),
      .CFG(cfg),
      .SUPPLY_RISE(supply),
      .BROWNOUT_LOW(brown),
      .EXT_RST_N(pin_n),
      .WDT_TIMEOUT(wdt),
      .RC_OSC(rc_clk),
      .OSC_IN(osc_clk),
      .WAKE_IRQ(wake),
      .REQ(req),
      .RDATA(rdata),
      .CORE_RST(core_rst),
      .COLD_RST(cold_rst),
      .CORE_STALL(stall),
      .RST_CAUSE(cause)
   );

   // ==========
   // Tasks
   task automatic end_sim;
      $display("Mismatches %0d, checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Gap cycle after each strobe keeps one driver assignment per step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] m,
                         input logic [7:0] exp);
      logic [7:0] d;
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #1 d = rdata;
      @(posedge clk);
      chk(d & m, exp);
   endtask

   // Sel 0 watches the core reset, 1 the stall
   task automatic wait_on(input bit sel, input logic lvl, input int lim);
      int k;
      k = 0;
      while ((sel ? stall : core_rst) !== lvl && k < lim)
      begin
         @(posedge clk);
         k++;
      end
      n = k;
      chk({7'h0, sel ? stall : core_rst}, {7'h0, lvl});
   endtask

   // ==========
   // Watchdog
   initial
   begin
      #300us;
      err_total++;
      end_sim;
   end

   // ==========
   // Tests
   initial
   begin
      idle(10);
      srst <= 1'b0;
      idle(3);
      chk({7'h0, core_rst}, 8'h01);
      chk({7'h0, cold_rst}, 8'h01);
      rd_chk(4'h1, 8'hFF, 8'h10);
      rd_chk(4'h0, 8'hFF, 8'h0C);
      wait_on(0, 1'b0, 300);
      chk({7'h0, n >= 45}, 8'h01);
      chk({7'h0, cold_rst}, 8'h00);
      rd_chk(4'h1, 8'hFF, 8'h04);
      wr(4'h0, 8'h03);
      rd_chk(4'h0, 8'hFF, 8'h0F);
      rd_chk(4'h7, 8'hFF, 8'h00);
      // Glitch, then a held pin
      pin_n <= 1'b0;
      idle(1);
      pin_n <= 1'b1;
      idle(12);
      chk({7'h0, core_rst}, 8'h00);
      pin_n <= 1'b0;
      wait_on(0, 1'b1, 20);
      idle(20);
      pin_n <= 1'b1;
      wait_on(0, 1'b0, 8);
      chk({7'h0, cold_rst}, 8'h00);
      rd_chk(4'h0, 8'hFF, 8'h2F);
      wdt <= 1'b1;
      wait_on(0, 1'b1, 8);
      wdt <= 1'b0;
      wait_on(0, 1'b0, 8);
      chk({5'h0, cause}, 8'h04);
      rd_chk(4'h0, 8'hFF, 8'h47);
      wr(4'h1, 8'h02);
      rd_chk(4'h0, 8'hFF, 8'h4F);
      // Sleep, then watchdog, pin and interrupt wake
      for (int i = 0; i < 3; i++)
      begin
         wr(4'h1, 8'h01);
         rd_chk(4'h1, 8'h01, 8'h01);
         rd_chk(4'h0, 8'h0C, 8'h08);
         chk({7'h0, stall}, 8'h01);
         if (i == 0)
            wdt <= 1'b1;
         else if (i == 1)
            pin_n <= 1'b0;
         else
            wake <= 1'b1;
         idle(10);
         chk({7'h0, core_rst}, {7'h0, i == 1});
         wdt <= 1'b0;
         pin_n <= 1'b1;
         wake <= 1'b0;
         wait_on(i != 1, 1'b0, 60);
         rd_chk(4'h0, 8'hFF, exp_wake[i]);
      end
      // Brown-out, disabled then enabled
      brown <= 1'b1;
      idle(20);
      chk({7'h0, core_rst}, 8'h00);
      brown <= 1'b0;
      cfg <= 4'h7;
      idle(2);
      brown <= 1'b1;
      idle(2);
      brown <= 1'b0;
      idle(10);
      chk({7'h0, core_rst}, 8'h00);
      brown <= 1'b1;
      wait_on(0, 1'b1, 20);
      rd_chk(4'h1, 8'hFF, 8'h08);
      brown <= 1'b0;
      idle(6);
      rd_chk(4'h1, 8'hFF, 8'h10);
      brown <= 1'b1;
      idle(10);
      rd_chk(4'h1, 8'hFF, 8'h08);
      brown <= 1'b0;
      wait_on(0, 1'b0, 300);
      rd_chk(4'h0, 8'hFF, 8'h1E);
      // Supply rise
      supply <= 1'b1;
      wait_on(0, 1'b1, 10);
      idle(1);
      chk({7'h0, cold_rst}, 8'h01);
      supply <= 1'b0;
      wait_on(0, 1'b0, 300);
      rd_chk(4'h0, 8'hFE, 8'h0C);
      // Every oscillator code, delay off
      for (int m = 0; m < 4; m++)
      begin
         cfg <= {m[1:0], 2'b10};
         srst <= 1'b1;
         idle(4);
         srst <= 1'b0;
         idle(3);
         chk({7'h0, core_rst}, {7'h0, m != 3});
      end
      end_sim;
   end
endmodule
